// [core/autoneg_cfg_pkg.sv]
package autoneg_cfg_pkg;

	// ****************************************
	// Register map and field layout
	// ****************************************
	localparam logic [7:0]  CFG_INDEX      = 8'h1e;
	localparam logic [9:0]  CFG_BYTE_ADDR  = 10'h078;
	localparam int          FAST_PD_BIT    = 15;
	localparam int          SHORT_NEG_BIT  = 14;
	localparam int          SEL_HI_BIT     = 13;
	localparam int          SEL_LO_BIT     = 12;
	localparam logic [15:0] CFG_RW_MASK    = 16'hf000;
	localparam logic [15:0] CFG_RESET      = 16'h0000;

	// ****************************************
	// Timer durations in ms
	// ****************************************
	localparam int STD_BREAK_MS  = 1500;
	localparam int STD_INHIB_MS  = 750;
	localparam int STD_WAIT_MS   = 500;
	localparam int S0_BREAK_MS   = 80;
	localparam int S0_INHIB_MS   = 50;
	localparam int S0_WAIT_MS    = 35;
	localparam int S1_BREAK_MS   = 120;
	localparam int S1_INHIB_MS   = 75;
	localparam int S1_WAIT_MS    = 50;
	localparam int S2_BREAK_MS   = 240;
	localparam int S2_INHIB_MS   = 150;
	localparam int S2_WAIT_MS    = 100;
	localparam int STD_PD_MS     = 50;
	localparam int FAST_PD_MS    = 15;

	// Clock rate and ms tick
	localparam int CLK_HZ        = 25000000;
	localparam int MS_CYCLES     = CLK_HZ / 1000;
	localparam int MS_CNT_W      = 15;
	localparam int DUR_W         = 11;

	typedef enum logic [1:0]
	{
		SEL_80_50_35,
		SEL_120_75_50,
		SEL_240_150_100,
		SEL_UNDEFINED
	} timer_sel_t;

endpackage

// [core/autoneg_timer_config.sv]
// Functional notes
// - Fast bit shortens parallel-detect link-up time
// - Short enable selects chosen timer durations
// - Select codes give break/inhibit/wait durations
// - Select ignored while short enable clear
`timescale 1ns/10ps
module autoneg_timer_config
	import autoneg_cfg_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               resetn,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [9:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	output logic                    wb_err_o,
	output logic      [DUR_W-1:0]   break_link_ms,
	output logic      [DUR_W-1:0]   link_fail_inhibit_ms,
	output logic      [DUR_W-1:0]   autoneg_wait_ms,
	output logic      [DUR_W-1:0]   parallel_detect_ms,
	output logic                    ms_tick
);

	// ****************************************
	// Bus decode
	// ****************************************
	logic [15:0]         cfg_reg;
	logic [15:0]         cfg_next;
	logic                ack_reg;
	logic                err_reg;
	logic [31:0]         rdata_reg;
	logic [MS_CNT_W-1:0] ms_cnt_reg;
	logic [DUR_W-1:0]    brk_reg;
	logic [DUR_W-1:0]    inh_reg;
	logic [DUR_W-1:0]    wait_reg;
	logic [DUR_W-1:0]    pd_reg;
	logic                tick_reg;
	wire                 req;
	wire                 hit;
	wire                 wr_hit;
	wire  [15:0]         lane_mask;
	wire                 short_en;
	wire                 fast_pd;
	timer_sel_t          sel;

	function automatic logic [DUR_W-1:0] dur(input int ms);
		dur = DUR_W'(ms);
	endfunction

	// New request only while no answer is out, so ack is one cycle
	assign req       = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
	assign hit       = (wb_adr_i == CFG_BYTE_ADDR);
	assign wr_hit    = req && hit && wb_we_i;
	assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & CFG_RW_MASK;
	assign cfg_next  = (cfg_reg & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
	assign wb_ack_o  = ack_reg;
	assign wb_err_o  = err_reg;
	assign wb_dat_o  = rdata_reg;

	// ****************************************
	// Register and bus answer
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			cfg_reg   <= CFG_RESET;
			ack_reg   <= 1'b0;
			err_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= req && hit;
			err_reg <= req && !hit;   // Unmapped address answers with err
			if (wr_hit)
				cfg_reg <= cfg_next;
			if (req && hit && !wb_we_i)
				rdata_reg <= {16'h0000, cfg_reg};
			else
				rdata_reg <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Timer selection
	// ****************************************
	assign short_en = cfg_reg[SHORT_NEG_BIT];
	assign fast_pd  = cfg_reg[FAST_PD_BIT];
	assign sel      = timer_sel_t'(cfg_reg[SEL_HI_BIT:SEL_LO_BIT]);

	// Durations registered so outputs come from flip-flops
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			brk_reg  <= dur(STD_BREAK_MS);
			inh_reg  <= dur(STD_INHIB_MS);
			wait_reg <= dur(STD_WAIT_MS);
			pd_reg   <= dur(STD_PD_MS);
		end
		else
		begin
			pd_reg <= fast_pd ? dur(FAST_PD_MS) : dur(STD_PD_MS);
			if (!short_en)   // Select ignored here
			begin
				brk_reg  <= dur(STD_BREAK_MS);
				inh_reg  <= dur(STD_INHIB_MS);
				wait_reg <= dur(STD_WAIT_MS);
			end
			else
			begin
				case (sel)
					SEL_80_50_35:
					begin
						brk_reg  <= dur(S0_BREAK_MS);
						inh_reg  <= dur(S0_INHIB_MS);
						wait_reg <= dur(S0_WAIT_MS);
					end
					SEL_120_75_50:
					begin
						brk_reg  <= dur(S1_BREAK_MS);
						inh_reg  <= dur(S1_INHIB_MS);
						wait_reg <= dur(S1_WAIT_MS);
					end
					SEL_240_150_100:
					begin
						brk_reg  <= dur(S2_BREAK_MS);
						inh_reg  <= dur(S2_INHIB_MS);
						wait_reg <= dur(S2_WAIT_MS);
					end
					default:   // No durations defined
					begin
						brk_reg  <= dur(STD_BREAK_MS);
						inh_reg  <= dur(STD_INHIB_MS);
						wait_reg <= dur(STD_WAIT_MS);
					end
				endcase
			end
		end
	end

	// ****************************************
	// Millisecond enable for the negotiation timers
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			ms_cnt_reg <= '0;
			tick_reg   <= 1'b0;
		end
		else if (ms_cnt_reg == MS_CNT_W'(MS_CYCLES - 1))
		begin
			ms_cnt_reg <= '0;
			tick_reg   <= 1'b1;
		end
		else
		begin
			ms_cnt_reg <= ms_cnt_reg + 1'b1;
			tick_reg   <= 1'b0;
		end
	end

	assign break_link_ms        = brk_reg;
	assign link_fail_inhibit_ms = inh_reg;
	assign autoneg_wait_ms      = wait_reg;
	assign parallel_detect_ms   = pd_reg;
	assign ms_tick              = tick_reg;

	// ****************************************
	// Checks
	// ****************************************
	property p_fast_pd;
		@(posedge sys_clk) disable iff (!resetn)
		fast_pd |=> parallel_detect_ms == dur(FAST_PD_MS);
	endproperty
	a_fast_pd: assert property (p_fast_pd) else $error("pd time wrong");

	property p_std;
		@(posedge sys_clk) disable iff (!resetn)
		!short_en |=> break_link_ms == dur(STD_BREAK_MS)
			&& autoneg_wait_ms == dur(STD_WAIT_MS);
	endproperty
	a_std: assert property (p_std) else $error("std timers wrong");

	property p_sel0;
		@(posedge sys_clk) disable iff (!resetn)
		short_en && sel == SEL_80_50_35 |=> break_link_ms == dur(S0_BREAK_MS)
			&& link_fail_inhibit_ms == dur(S0_INHIB_MS);
	endproperty
	a_sel0: assert property (p_sel0) else $error("code 00 wrong");

	property p_sel2;
		@(posedge sys_clk) disable iff (!resetn)
		short_en && sel == SEL_240_150_100 |=>
			autoneg_wait_ms == dur(S2_WAIT_MS);
	endproperty
	a_sel2: assert property (p_sel2) else $error("code 10 wrong");

	property p_undef;
		@(posedge sys_clk) disable iff (!resetn)
		short_en && sel == SEL_UNDEFINED |=>
			link_fail_inhibit_ms == dur(STD_INHIB_MS);
	endproperty
	a_undef: assert property (p_undef) else $error("code 11 wrong");

	sequence s_wr;
		wr_hit && wb_sel_i[1];
	endsequence
	property p_write;
		@(posedge sys_clk) disable iff (!resetn)
		s_wr |=> ack_reg ##0 cfg_reg[15:12] == $past(wb_dat_i[15:12]);
	endproperty
	a_write: assert property (p_write) else $error("write lost");

	property p_ack_one;
		@(posedge sys_clk) disable iff (!resetn)
		ack_reg |=> !ack_reg;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");

	property p_tick;
		@(posedge sys_clk) disable iff (!resetn)
		ms_tick |=> !ms_tick [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("tick too often");

endmodule

// [tb/link_partner_model.sv]
`timescale 1ns/10ps
module link_partner_model
	import autoneg_cfg_pkg::*;
(
	input  wire logic             short_en,
	input  wire logic [1:0]       sel,
	output logic      [DUR_W-1:0] break_ms
);
	// Far end set up like the local side; code 11 treated as standard
	assign break_ms = (!short_en || sel == 2'b11) ? DUR_W'(STD_BREAK_MS) :
		(sel == 2'b00) ? DUR_W'(S0_BREAK_MS) :
		(sel == 2'b01) ? DUR_W'(S1_BREAK_MS) : DUR_W'(S2_BREAK_MS);
endmodule

// [tb/tb_autoneg_timer_config.sv]
`timescale 1ns/10ps
module tb_autoneg_timer_config
	import autoneg_cfg_pkg::*;
;
	logic sys_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, e, p_en = 0;
	logic [9:0] adr = 0;
	logic [3:0] sel = 0;
	logic [1:0] p_sel = 0;
	logic [31:0] wdat = 0, rd;
	wire [31:0] dat_o;
	wire ack, err, tick;
	wire [DUR_W-1:0] brk, inh, wt, pd, p_brk;
	int n_fail = 0, tests_run = 0, k;

	always #20 sys_clk = ~sys_clk;

	autoneg_timer_config uut (.sys_clk(sys_clk), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.wb_err_o(err), .break_link_ms(brk), .link_fail_inhibit_ms(inh),
		.autoneg_wait_ms(wt), .parallel_detect_ms(pd), .ms_tick(tick));
	link_partner_model partner (.short_en(p_en), .sel(p_sel),
		.break_ms(p_brk));

	// ****************************************
	// Tasks
	// ****************************************
	task summarize;
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [43:0] got, input logic [43:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle; hangs cut off after 20 edges
	task bus(input logic w, input logic [9:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge sys_clk);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
		k = 0;
		do
		begin
			@(posedge sys_clk);
			k++;
		end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
		rd = dat_o;
		e = err;
		{cyc, stb} <= 2'b00;
		if (k >= 20)
			n_fail++;
	endtask

	// Expected timers from the register value
	function logic [43:0] exp_t(input logic [15:0] r);
		logic [1:0] s;
		s = r[13:12];
		exp_t[10:0] = r[15] ? 11'(FAST_PD_MS) : 11'(STD_PD_MS);
		if (!r[14] || s == 2'b11)
			exp_t[43:11] = {11'(STD_BREAK_MS), 11'(STD_INHIB_MS), 11'(STD_WAIT_MS)};
		else if (s == 2'b00)
			exp_t[43:11] = {11'(S0_BREAK_MS), 11'(S0_INHIB_MS), 11'(S0_WAIT_MS)};
		else if (s == 2'b01)
			exp_t[43:11] = {11'(S1_BREAK_MS), 11'(S1_INHIB_MS), 11'(S1_WAIT_MS)};
		else
			exp_t[43:11] = {11'(S2_BREAK_MS), 11'(S2_INHIB_MS), 11'(S2_WAIT_MS)};
	endfunction

	// Write, read back, then check timers and partner agreement
	task cfg(input logic [31:0] v, input logic [3:0] s, input logic [15:0] x);
		bus(1'b1, CFG_BYTE_ADDR, s, v);
		bus(1'b0, CFG_BYTE_ADDR, 4'hf, 32'h0);
		p_en <= x[14];
		p_sel <= x[13:12];
		chk(rd, x);
		chk({brk, inh, wt, pd}, exp_t(x));
		@(posedge sys_clk);
		chk(brk, p_brk);
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		cfg(32'h0, 4'h0, 16'h0);
		for (int c = 0; c < 4; c++)
			cfg({18'h1, c[1:0], 12'hfff}, 4'hf, {2'b01, c[1:0], 12'h0});
		cfg(32'h0000_a000, 4'hf, 16'ha000);
		cfg(32'h0000_7000, 4'hd, 16'ha000);
		bus(1'b1, 10'h07c, 4'hf, 32'h0000_4000);
		chk(e, 1'b1);
		cfg(32'h0000_2000, 4'h0, 16'ha000);
		// First tick, then one whole ms period up to the next tick
		k = 0;
		while (tick !== 1'b1 && k < 30000)
		begin
			@(posedge sys_clk);
			k++;
		end
		chk(tick, 1'b1);
		k = 0;
		do
		begin
			@(posedge sys_clk);
			k++;
		end while (tick !== 1'b1 && k < 30000);
		chk(k, MS_CYCLES);
		bus(1'b0, 10'h07c, 4'hf, 32'h0);
		chk(e, 1'b1);
		summarize;
	end

	initial
	begin
		// Two ms periods plus bus traffic fit well inside this
		#(40 * 60000);
		n_fail++;
		summarize;
	end
endmodule
